// file: include/irpd_defs.vh
// Constants for the request, reset and output power-down control block.
// Assumes a single 125 MHz core clock and plain-port configuration.
// Overview of operation
// - Only general and alarm flags raise requests
// - Mask 1 blocks; masks reset blocking
// - Sticky flag; read clears unless condition persists
// - Level select 1 level default, 0 edge
// - Edge mode: one-clock pulse per event
// - Level request held until flag read
// - Polarity 1 active high, 0 low
// - Edge path one clock latency; level combinational
// - Per flag edge event and sticky; OR unmasked
// - Unmask: level fires now, edge waits
// - Always flagged; pin gated; alarms drive alarm_n
// - Reference fault acts per response field
// - Trim loaded, CRC checked, reload trigger
// - Special bit: soft reset reloads trim
// - Powerdown bit: output high impedance until cleared
// - Selected alarms force powerdown while active
// - Code register kept and writable in powerdown
// - Alarm released after trim load, within 100us
// - Pin reset keeps trim, resets registers
// - Code 0xad written resets the device
// - Soft reset pulses alarm_n, keeps oscillator
// - Special register cleared only at power-on
`ifndef IRPD_DEFS_VH
`define IRPD_DEFS_VH
`define IRPD_FLAG_W 8
`define IRPD_MASK_RST 8'hff
`define IRPD_LEVEL_SEL_RST 1'b1
`define IRPD_POL_RST 1'b0
`define IRPD_RESP_SEL_RST 8'h00
`define IRPD_REF_ACT_RST 2'h0
`define IRPD_REF_FAULT_BIT 0
`define IRPD_REF_ACT_NONE 2'h0
`define IRPD_REF_ACT_PD 2'h1
`define IRPD_REF_ACT_ALARMV 2'h2
`define IRPD_REF_ACT_CLEAR 2'h3
`define IRPD_SOFT_RESET_CODE 8'had
`define IRPD_CLK_MHZ 125
`define IRPD_TPOR_US 100
`define IRPD_TPOR_CYCLES (`IRPD_TPOR_US * `IRPD_CLK_MHZ)
`endif

// file: core/irpd_flag_bank.v
// Eight sticky event flags with masks and edge events.
// Conditions arrive asynchronous; read strobes are core_clk pulses, clear is a core_clk-synchronous level.
`timescale 1ns/100ps
`include "irpd_defs.vh"
module irpd_flag_bank
(
    input wire core_clk, // Core clock
    input wire rst_n, // Power-on reset, active low
    input wire clear, // Synchronous clear from device reset
    input wire [7:0] cond, // Raw event conditions
    input wire [7:0] mask, // 1 blocks the flag's request; the flag still sets
    input wire read_strobe, // Host read of this flag register
    output wire [7:0] flags, // Sticky flags
    output wire [7:0] cond_now, // Synchronised conditions
    output wire level_req, // OR of unmasked sticky flags and live conditions
    output reg edge_req // One-cycle edge request
);
    reg [7:0] sync1;
    reg [7:0] sync2;
    reg [7:0] prev;
    reg [7:0] sticky;
    wire [7:0] event_edge;
    genvar i;

    assign cond_now = sync2;
    assign flags = sticky;
    // Level request from live and sticky flags, ahead of the edge path
    assign level_req = |((sticky | sync2) & ~mask);

    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_flag
            // Two-stage synchroniser, then edge detect and sticky copy
            always @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                    prev[i] <= 1'b0;
                    sticky[i] <= 1'b0;
                end
                else
                begin
                    sync1[i] <= cond[i];
                    sync2[i] <= sync1[i];
                    prev[i] <= sync2[i];
                    if (clear)
                        sticky[i] <= 1'b0;
                    else
                        sticky[i] <= sync2[i] | (sticky[i] & ~read_strobe);
                end
            end
            assign event_edge[i] = sync2[i] & ~prev[i];
        end
    endgenerate

    // Edge request registered: one clock wide and one clock late
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            edge_req <= 1'b0;
        else if (clear)
            edge_req <= 1'b0;
        else
            edge_req <= |(event_edge & ~mask);
    end
endmodule // irpd_flag_bank

// file: core/irpd_reset_ctrl.v
// Reset sequencing: pin reset sync, soft reset pulse, trim load control.
// Trim memory answers trim_load_start with trim_load_done and a CRC result.
`timescale 1ns/100ps
`include "irpd_defs.vh"
module irpd_reset_ctrl
#(
    parameter TRIM_TIMEOUT = `IRPD_TPOR_CYCLES
)
(
    input wire core_clk, // Core clock
    input wire rst_n, // Power-on reset, active low
    input wire reset_pin_n, // Reset pin, asynchronous, active low
    input wire soft_reset, // One-cycle soft reset request
    input wire trim_reload_trigger, // Request a fresh trim load
    input wire trim_reload_on_soft_reset, // Soft reset also reloads trim
    input wire trim_load_done, // Trim memory finished
    input wire trim_crc_ok, // CRC result with done
    output wire dev_reset, // Register and interface reset, level
    output reg trim_load_start, // One-cycle start of a trim load
    output reg trim_busy, // Load in progress
    output reg por_load_done, // First load after power-on finished
    output reg trim_crc_error // Last load failed CRC or timed out
);
    localparam ST_START = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_IDLE = 2'd2;
    reg pin_sync1;
    reg pin_sync2;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [13:0] timer;

    // Pin reset synchronised; release follows core_clk
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
        end
        else
        begin
            pin_sync1 <= reset_pin_n;
            pin_sync2 <= pin_sync1;
        end
    end

    assign dev_reset = ~pin_sync2 | soft_reset;

    // Load sequencer; pin reset never restarts it
    always @*
    begin
        next_state = state;
        case (state)
            ST_START: next_state = ST_WAIT;
            ST_WAIT:
                if (trim_load_done || timer == 14'd0)
                    next_state = ST_IDLE;
            ST_IDLE:
                if (trim_reload_trigger || (soft_reset && trim_reload_on_soft_reset))
                    next_state = ST_START;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_START;
            timer <= 14'd0;
            trim_load_start <= 1'b1; // Power-on load starts on release
            trim_busy <= 1'b1;
            por_load_done <= 1'b0;
            trim_crc_error <= 1'b0;
        end
        else
        begin
            state <= next_state;
            trim_load_start <= (next_state == ST_START);
            trim_busy <= (next_state != ST_IDLE);
            if (state == ST_START)
                timer <= TRIM_TIMEOUT[13:0];
            else if (timer != 14'd0)
                timer <= timer - 14'd1;
            if (state == ST_WAIT && next_state == ST_IDLE)
            begin
                por_load_done <= 1'b1;
                trim_crc_error <= ~(trim_load_done & trim_crc_ok);
            end
        end
    end
endmodule // irpd_reset_ctrl

// file: core/irpd_top.v
// Request, reset and output power-down control of the converter.
// Configuration writes arrive as core_clk strobes with a shared 16-bit data word;
// event conditions and the reset pin are asynchronous.
`timescale 1ns/100ps
`include "irpd_defs.vh"
module irpd_top
#(
    parameter TRIM_TIMEOUT = `IRPD_TPOR_CYCLES
)
(
    input wire core_clk, // Core clock, 125 MHz
    input wire rst_n, // Power-on reset, active low
    input wire reset_pin_n, // Hardware reset pin, active low
    input wire [7:0] gen_cond, // General event conditions
    input wire [7:0] alarm_cond, // Alarm event conditions
    input wire gen_read, // Host read of general flags
    input wire alarm_read, // Host read of alarm flags
    input wire [15:0] cfg_wdata, // Write data shared by strobes
    input wire gen_mask_we, // Write general mask
    input wire alarm_mask_we, // Write alarm mask
    input wire config_we, // Write level, polarity, pin enable
    input wire alarm_response_we, // Write alarm response select
    input wire output_cfg_we, // Write output powerdown bit
    input wire special_cfg_we, // Write special configuration
    input wire soft_reset_we, // Write soft reset field
    input wire code_we, // Write converter code
    input wire trim_reload_trigger, // Start trim reload
    input wire trim_load_done, // Trim memory done
    input wire trim_crc_ok, // Trim CRC good
    output reg [7:0] general_event_flags, // General sticky flags
    output reg [7:0] alarm_event_flags, // Alarm sticky flags
    output wire general_request_line, // Request pin
    output wire alarm_n, // Alarm pin, active low
    output reg output_hiz, // Output amplifier off, pin high impedance
    output reg [1:0] ref_fault_drive, // Output action for reference fault
    output reg [15:0] code_out, // Converter code register
    output wire serial_wdt_reset, // Reset to serial interfaces and watchdog
    output wire osc_reset, // Reset to oscillator, pin reset only
    output wire trim_load_start, // Start a trim memory load
    output wire trim_busy, // Trim load in progress
    output wire trim_crc_error, // Trim CRC failed
    output reg uart_break_access // Uart full map access bit
);
    reg [7:0] gen_mask;
    reg [7:0] alarm_mask;
    reg request_level_select;
    reg request_polarity;
    reg irq_pin_en;
    reg [7:0] alarm_response_select;
    reg [1:0] reference_fault_action;
    reg output_powerdown;
    reg trim_reload_on_soft_reset;
    reg soft_reset;
    wire dev_reset;
    wire por_load_done;
    wire [7:0] gen_flags;
    wire [7:0] alarm_flags;
    wire [7:0] alarm_now;
    wire gen_level;
    wire gen_edge;
    wire alarm_level;
    wire alarm_edge;
    wire req_raw;
    wire alarm_raw;
    wire pd_alarm;
    wire ref_fault;

    // Soft reset decode: one clock pulse, well under 20 ns
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_reset <= 1'b0;
        else
            soft_reset <= soft_reset_we && (cfg_wdata[7:0] == `IRPD_SOFT_RESET_CODE);
    end

    // Reset and trim sequencing
    irpd_reset_ctrl #(
        .TRIM_TIMEOUT(TRIM_TIMEOUT)
    ) u_reset (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reset_pin_n(reset_pin_n),
        .soft_reset(soft_reset),
        .trim_reload_trigger(trim_reload_trigger),
        .trim_reload_on_soft_reset(trim_reload_on_soft_reset),
        .trim_load_done(trim_load_done),
        .trim_crc_ok(trim_crc_ok),
        .dev_reset(dev_reset),
        .trim_load_start(trim_load_start),
        .trim_busy(trim_busy),
        .por_load_done(por_load_done),
        .trim_crc_error(trim_crc_error)
    );

    assign serial_wdt_reset = dev_reset;
    assign osc_reset = dev_reset & ~soft_reset;

    // General event flags
    irpd_flag_bank u_gen (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(dev_reset),
        .cond(gen_cond),
        .mask(gen_mask),
        .read_strobe(gen_read),
        .flags(gen_flags),
        .cond_now(),
        .level_req(gen_level),
        .edge_req(gen_edge)
    );

    // Alarm event flags
    irpd_flag_bank u_alarm (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(dev_reset),
        .cond(alarm_cond),
        .mask(alarm_mask),
        .read_strobe(alarm_read),
        .flags(alarm_flags),
        .cond_now(alarm_now),
        .level_req(alarm_level),
        .edge_req(alarm_edge)
    );

    // Flag readback registered for the host
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            general_event_flags <= 8'h00;
            alarm_event_flags <= 8'h00;
        end
        else
        begin
            general_event_flags <= gen_flags;
            alarm_event_flags <= alarm_flags;
        end
    end

    // Masks and request configuration, restored to reset values by any reset
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gen_mask <= `IRPD_MASK_RST;
            alarm_mask <= `IRPD_MASK_RST;
            request_level_select <= `IRPD_LEVEL_SEL_RST;
            request_polarity <= `IRPD_POL_RST;
            irq_pin_en <= 1'b0;
            uart_break_access <= 1'b0;
        end
        else if (dev_reset)
        begin
            gen_mask <= `IRPD_MASK_RST;
            alarm_mask <= `IRPD_MASK_RST;
            request_level_select <= `IRPD_LEVEL_SEL_RST;
            request_polarity <= `IRPD_POL_RST;
            irq_pin_en <= 1'b0;
            uart_break_access <= 1'b0;
        end
        else
        begin
            if (gen_mask_we)
                gen_mask <= cfg_wdata[7:0];
            if (alarm_mask_we)
                alarm_mask <= cfg_wdata[7:0];
            if (config_we)
            begin
                request_level_select <= cfg_wdata[0];
                request_polarity <= cfg_wdata[1];
                irq_pin_en <= cfg_wdata[2];
                uart_break_access <= cfg_wdata[3];
            end
        end
    end

    // Alarm response and output configuration
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_response_select <= `IRPD_RESP_SEL_RST;
            reference_fault_action <= `IRPD_REF_ACT_RST;
            output_powerdown <= 1'b0;
        end
        else if (dev_reset)
        begin
            alarm_response_select <= `IRPD_RESP_SEL_RST;
            reference_fault_action <= `IRPD_REF_ACT_RST;
            output_powerdown <= 1'b0;
        end
        else
        begin
            if (alarm_response_we)
            begin
                alarm_response_select <= cfg_wdata[7:0];
                reference_fault_action <= cfg_wdata[9:8];
            end
            if (output_cfg_we)
                output_powerdown <= cfg_wdata[0];
        end
    end

    // Special configuration survives pin and soft reset
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            trim_reload_on_soft_reset <= 1'b0;
        else if (special_cfg_we)
            trim_reload_on_soft_reset <= cfg_wdata[0];
    end

    // Converter code: untouched by powerdown, writable except during dev_reset
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            code_out <= 16'h0000;
        else if (dev_reset)
            code_out <= 16'h0000;
        else if (code_we)
            code_out <= cfg_wdata;
    end

    // Request selection by style, pin gated and polarity applied
    assign req_raw = request_level_select ? (gen_level | alarm_level) : (gen_edge | alarm_edge);
    assign alarm_raw = request_level_select ? alarm_level : alarm_edge;
    assign general_request_line = irq_pin_en ? (req_raw ~^ request_polarity) : ~request_polarity;
    assign alarm_n = ~(alarm_raw | ~por_load_done | soft_reset);

    // Alarm-driven powerdown and reference fault action
    assign ref_fault = alarm_now[`IRPD_REF_FAULT_BIT];
    assign pd_alarm = |(alarm_now & alarm_response_select) |
                      (ref_fault & (reference_fault_action == `IRPD_REF_ACT_PD));

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_hiz <= 1'b0;
            ref_fault_drive <= `IRPD_REF_ACT_NONE;
        end
        else
        begin
            output_hiz <= output_powerdown | pd_alarm;
            ref_fault_drive <= ref_fault ? reference_fault_action : `IRPD_REF_ACT_NONE;
        end
    end
endmodule // irpd_top

// file: tb/irpd_trim_model.sv
// Trim memory model that answers load starts after a fixed delay.
// Driven by trim_load_start of irpd_top; the bench chooses the CRC result.
`timescale 1ns/100ps
module irpd_trim_model
#(
    parameter DELAY = 5
)
(
    input wire core_clk, // Clock
    input wire rst_n, // Reset, active low
    input wire trim_load_start, // Load request
    input wire crc_good, // CRC result to report
    output reg trim_load_done, // Load finished pulse
    output reg trim_crc_ok // CRC result, valid with done only
);
    integer cnt;
    // Count down from a start; the CRC line shows junk outside done
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            trim_load_done <= 1'b0;
            trim_crc_ok <= 1'b0;
        end
        else
        begin
            trim_load_done <= (cnt == 1);
            trim_crc_ok <= (cnt == 1) ? crc_good : ~crc_good;
            if (trim_load_start)
                cnt <= DELAY;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule // irpd_trim_model

// file: tb/irpd_props.sv
// Port checker for the request, reset and powerdown block.
// Bound into irpd_top; sees its ports only.
`timescale 1ns/100ps
module irpd_props
(
    input wire core_clk, // Clock
    input wire rst_n, // Power-on reset
    input wire reset_pin_n, // Reset pin
    input wire [15:0] cfg_wdata, // Write data
    input wire gen_read, // General flag read
    input wire code_we, // Code write
    input wire output_cfg_we, // Powerdown write
    input wire soft_reset_we, // Soft reset write
    input wire trim_reload_trigger, // Reload trigger
    input wire trim_load_done, // Trim done
    input wire [7:0] general_event_flags, // Flags
    input wire alarm_n, // Alarm pin
    input wire output_hiz, // Output off
    input wire [15:0] code_out, // Code register
    input wire serial_wdt_reset, // Serial reset
    input wire osc_reset, // Oscillator reset
    input wire trim_load_start, // Load start
    input wire trim_busy // Load busy
);
    reg load_seen;
    wire soft_ok = soft_reset_we && cfg_wdata[7:0] == 8'had;
    // Remembers that trim_load_done has been seen once
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            load_seen <= 1'b0;
        else if (trim_load_done)
            load_seen <= 1'b1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // No reset of either kind in flight
    sequence s_quiet;
        (reset_pin_n && !soft_ok) [*4];
    endsequence
    a_soft_reset_pulse: assert property (s_quiet ##1 soft_ok |=> serial_wdt_reset && !alarm_n && !osc_reset)
        else $error("soft reset pulse missing");
    a_wrong_code_idle: assert property (s_quiet ##1 (soft_reset_we && !soft_ok) |=> !serial_wdt_reset)
        else $error("wrong code reset");
    a_code_write: assert property (s_quiet ##1 code_we |=> code_out == $past(cfg_wdata))
        else $error("code not written");
    a_code_hold: assert property (s_quiet ##1 (output_hiz && !code_we) |=> $stable(code_out))
        else $error("code moved in powerdown");
    a_hiz_enter: assert property (s_quiet ##1 (output_cfg_we && cfg_wdata[0]) |-> ##[1:2] output_hiz)
        else $error("powerdown not entered");
    a_osc_pin_only: assert property (osc_reset |-> serial_wdt_reset)
        else $error("oscillator reset alone");
    a_pin_reset_acts: assert property (!reset_pin_n [*3] |-> osc_reset)
        else $error("pin reset not applied");
    a_trim_start: assert property (s_quiet ##1 (trim_reload_trigger && !trim_busy) |=> trim_load_start)
        else $error("trim reload not started");
    a_alarm_until_load: assert property (!load_seen |-> !alarm_n)
        else $error("alarm released early");
    a_flags_sticky: assert property (s_quiet ##1 (!gen_read && !$past(gen_read) && !$past(gen_read, 2))
        |=> (general_event_flags | ~$past(general_event_flags)) == 8'hff)
        else $error("flag dropped without read");
    c_soft: cover property (soft_ok);
    c_hiz: cover property ($rose(output_hiz));
    c_flag: cover property (general_event_flags != 8'h00);
endmodule // irpd_props
bind irpd_top irpd_props u_props (.core_clk, .rst_n, .reset_pin_n, .cfg_wdata, .gen_read, .code_we,
    .output_cfg_we, .soft_reset_we, .trim_reload_trigger, .trim_load_done, .general_event_flags, .alarm_n,
    .output_hiz, .code_out, .serial_wdt_reset, .osc_reset, .trim_load_start, .trim_busy);

// file: tb/irpd_top_bench.sv
// Self-checking bench for irpd_top with a trim memory model.
// Short trim timeout; checks made one step after clock edges.
`timescale 1ns/100ps
`include "irpd_defs.vh"
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin $display("CHECK FAILED %0t %s", $time, m); miscompares++; end end
module irpd_top_bench;
    reg core_clk = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1, gen_read = 1'b0, alarm_read = 1'b0;
    reg trig = 1'b0, crc_good = 1'b1, act = 1'b0;
    reg [7:0] gen_cond = 8'h00, alarm_cond = 8'h00, we = 8'h00;
    reg [15:0] cfg_wdata = 16'h0000;
    wire [7:0] general_event_flags, alarm_event_flags;
    wire [15:0] code_out;
    wire [1:0] ref_fault_drive;
    wire general_request_line, alarm_n, output_hiz, serial_wdt_reset, osc_reset, trim_load_start, trim_busy;
    wire trim_crc_error, uart_break_access, trim_load_done, trim_crc_ok;
    integer miscompares = 0, comparisons = 0, cycles = 0, n_line, n_srst, n_start, n_alarm, n_osc, f_line, f_flag, k;
    irpd_top #(.TRIM_TIMEOUT(20)) u_dut (.core_clk, .rst_n, .reset_pin_n, .gen_cond, .alarm_cond, .gen_read,
        .alarm_read, .cfg_wdata, .gen_mask_we(we[0]), .alarm_mask_we(we[1]), .config_we(we[2]),
        .alarm_response_we(we[3]), .output_cfg_we(we[4]), .special_cfg_we(we[5]), .soft_reset_we(we[6]),
        .code_we(we[7]), .trim_reload_trigger(trig), .trim_load_done, .trim_crc_ok, .general_event_flags,
        .alarm_event_flags, .general_request_line, .alarm_n, .output_hiz, .ref_fault_drive, .code_out,
        .serial_wdt_reset, .osc_reset, .trim_load_start, .trim_busy, .trim_crc_error, .uart_break_access);
    irpd_trim_model u_trim (.core_clk, .rst_n, .trim_load_start, .crc_good, .trim_load_done, .trim_crc_ok);
    // Clock and hang guard
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    task print_verdict;
    begin
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // Write strobe i with data d
    task wr(input integer i, input [15:0] d);
    begin
        @(posedge core_clk); we <= 8'h01 << i; cfg_wdata <= d;
        @(posedge core_clk); we <= 8'h00; #1;
    end
    endtask
    task set(input [7:0] g, input [7:0] a);
    begin
        @(posedge core_clk); gen_cond <= g; alarm_cond <= a; #1;
    end
    endtask
    task rd(input g);
    begin
        @(posedge core_clk); gen_read <= g; alarm_read <= !g;
        @(posedge core_clk); gen_read <= 1'b0; alarm_read <= 1'b0; #1;
    end
    endtask
    // Sample n cycles, counting events and first appearances
    task watch(input integer n);
    begin
        n_line = 0; n_srst = 0; n_start = 0; n_alarm = 0; n_osc = 0; f_line = 99; f_flag = 99;
        for (k = 0; k < n; k++)
        begin
            if (general_request_line === act) begin n_line++; if (f_line == 99) f_line = k; end
            if (general_event_flags !== 8'h00 && f_flag == 99) f_flag = k;
            n_srst += (serial_wdt_reset === 1'b1); n_start += (trim_load_start === 1'b1);
            n_alarm += (alarm_n === 1'b0); n_osc += (osc_reset === 1'b1);
            @(posedge core_clk); #1;
        end
    end
    endtask
    task t_power_on;
    begin
        watch(1); `CHK(alarm_n, 1'b0, "alarm before load");
        watch(10); `CHK(alarm_n, 1'b1, "alarm after load");
        set(8'h01, 8'h08); watch(6); `CHK(general_event_flags, 8'h01, "flag set");
        `CHK(alarm_event_flags, 8'h08, "alarm flag");
        `CHK(alarm_n, 1'b1, "masked alarm");
        set(0, 0); watch(1); rd(1); rd(0); watch(5); `CHK(general_event_flags, 8'h00, "flag cleared");
        $display("test power_on done");
    end
    endtask
    task t_level;
    begin
        wr(2, 16'h0005); wr(0, 16'h0000); set(8'h02, 0); watch(8);
        `CHK(f_flag - f_line, 2, "level latency");
        `CHK(general_request_line, 1'b0, "active low");
        rd(1); watch(5); `CHK(general_event_flags, 8'h02, "set wins");
        set(0, 0); watch(5); `CHK(general_request_line, 1'b0, "held until read");
        rd(1); watch(5); `CHK(general_request_line, 1'b1, "dropped after read");
        $display("test level done");
    end
    endtask
    task t_edge;
    begin
        wr(2, 16'h0006); act = 1'b1; set(8'h04, 0); watch(8);
        `CHK(n_line, 1, "one pulse");
        `CHK(f_flag - f_line, 1, "edge latency");
        `CHK(general_event_flags, 8'h04, "sticky copy");
        wr(0, 16'h00ff); set(8'h0c, 0); watch(5); wr(0, 16'h0000); watch(8);
        `CHK(n_line, 0, "no pulse on unmask");
        wr(2, 16'h0007); watch(2); `CHK(general_request_line, 1'b1, "level on unmask");
        set(0, 0); watch(1); rd(1); watch(5);
        wr(2, 16'h0003); set(8'h10, 0); watch(6);
        `CHK(general_request_line, 1'b0, "pin disabled");
        `CHK(general_event_flags, 8'h10, "still flagged");
        wr(2, 16'h0007); watch(3); `CHK(general_request_line, 1'b1, "pin enabled");
        set(0, 0); rd(1); watch(5);
        $display("test edge done");
    end
    endtask
    task t_alarm;
    begin
        wr(1, 16'h0000); set(0, 8'h02); watch(6); `CHK(alarm_n, 1'b0, "alarm pin");
        set(0, 0); watch(4); `CHK(alarm_n, 1'b0, "alarm held");
        rd(0); watch(5); `CHK(alarm_n, 1'b1, "alarm released");
        $display("test alarm done");
    end
    endtask
    task t_powerdown;
    begin
        wr(7, 16'h1234); wr(4, 16'h0001); watch(20); `CHK(output_hiz, 1'b1, "powerdown held");
        wr(7, 16'hbeef); watch(3); `CHK(code_out, 16'hbeef, "write in powerdown");
        wr(4, 16'h0000); watch(4); `CHK(output_hiz, 1'b0, "powerdown left");
        `CHK(code_out, 16'hbeef, "code kept");
        wr(3, 16'h0006); set(0, 8'h06); watch(5); `CHK(output_hiz, 1'b1, "alarm powerdown");
        set(0, 8'h04); watch(5); `CHK(output_hiz, 1'b1, "other alarm holds");
        set(0, 0); watch(5); `CHK(output_hiz, 1'b0, "alarms gone");
        wr(3, 16'h0100); set(0, 8'h01); watch(5); `CHK(ref_fault_drive, `IRPD_REF_ACT_PD, "ref pd");
        wr(3, 16'h0300); watch(4); `CHK(ref_fault_drive, `IRPD_REF_ACT_CLEAR, "ref clear");
        set(0, 0); watch(5); `CHK(ref_fault_drive, `IRPD_REF_ACT_NONE, "no fault");
        rd(0); watch(4);
        $display("test powerdown done");
    end
    endtask
    task t_trim;
    begin
        for (integer j = 0; j < 2; j++)
        begin
            @(posedge core_clk); crc_good <= j[0]; trig <= 1'b1;
            @(posedge core_clk); trig <= 1'b0; #1; watch(12);
            `CHK(n_start, 1, "reload started");
            `CHK(trim_crc_error, j == 0, "crc result");
        end
        $display("test trim done");
    end
    endtask
    task t_resets;
    begin
        wr(2, 16'h0008); wr(5, 16'h0001); wr(7, 16'h5a5a); wr(6, 16'h00ac); watch(6);
        `CHK(n_srst, 0, "wrong code");
        wr(6, 16'h00ad); watch(8); `CHK(n_srst, 1, "soft pulse");
        `CHK(n_alarm, 1, "alarm pulse");
        `CHK(n_osc, 0, "oscillator kept");
        `CHK(n_start, 1, "soft reload");
        `CHK(code_out, 16'h0000, "code reset");
        `CHK(uart_break_access, 1'b0, "uart access cleared");
        wr(6, 16'h00ad); watch(8); `CHK(n_start, 1, "special kept");
        wr(2, 16'h0008); wr(7, 16'h5a5a); @(posedge core_clk); reset_pin_n <= 1'b0; #1;
        watch(13); `CHK(n_osc > 8, 1'b1, "pin reset");
        @(posedge core_clk); reset_pin_n <= 1'b1; #1;
        watch(1250); `CHK(n_start, 0, "no reload on pin");
        `CHK(code_out, 16'h0000, "registers reset");
        `CHK(uart_break_access, 1'b0, "uart access pin");
        wr(6, 16'h00ad); watch(6); `CHK(n_start, 1, "special after pin");
        wr(2, 16'h0008); watch(3); `CHK(uart_break_access, 1'b1, "uart restored");
        $display("test resets done");
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        t_power_on;
        t_level;
        t_edge;
        t_alarm;
        t_powerdown;
        t_trim;
        t_resets;
        print_verdict;
    end
endmodule // irpd_top_bench
